// File: dv/mcarb_host_model.sv
// mcarb_host_model: host side of the register port, single reads and
// writes with optional idle gaps. assumes strobes sampled on rising edge.
`timescale 1ns/1ps
module mcarb_host_model
  import mcarb_pkg::*;
(
  input  wire logic        clk_sys_in,
  output logic      [7:0]  reg_addr_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic      [15:0] reg_wdata_out,
  input  wire logic [15:0] reg_rdata_in
);
  // ---------------------------------------------------------------
  // bus idle state and pacing
  // ---------------------------------------------------------------
  logic slow;
  initial begin
    slow          = 1'b0;
    reg_addr_out  = 8'hFF;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 16'h5A5A;
  end

  task automatic gap();
    if (slow) repeat ($urandom_range(2, 0)) @(negedge clk_sys_in);
  endtask

  // ---------------------------------------------------------------
  // accesses: one-cycle strobe, released lines show inverse value
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    gap();
    @(negedge clk_sys_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    gap();
    @(negedge clk_sys_in);
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(negedge clk_sys_in);
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
    d            = reg_rdata_in;
  endtask

  task automatic freeze();
    wr(ADDR_REAL_TIME_LOW, 16'h0000);
  endtask

  task automatic set_block(input logic [15:0] n);
    wr(ADDR_READOUT_BLOCK_SIZE, n);
  endtask
endmodule

// File: dv/tb.sv
// tb: random and corner checks of the analyzer register bank.
// assumes a 100 MHz clock and a five-cycle millisecond prescaler.
`timescale 1ns/1ps
module tb
  import mcarb_pkg::*;
;
  // ---------------------------------------------------------------
  // signals, design and host
  // ---------------------------------------------------------------
  localparam int TICKS = 5;
  logic        clk_sys_in, rst_b_in, reg_wr_in, reg_rd_in;
  logic [7:0]  reg_addr_in, trimmer_control_out;
  logic [15:0] reg_wdata_in, reg_rdata_out, sample_buffer_level_in;
  logic [15:0] test_dac_out, readout_block_size_out;
  logic        timers_enable_in, dac_test_mode_in, gate_auto_in, flag_clear_in;
  logic        buffer_full_in, conv_idle_in, conv_track_in, conv_settle_in;
  logic        conversion_done_in, buffer_clear_out, soft_reset_out, mem_full_clear_out;
  int          fails, n_tests, n_clr, n_rst, n_mfc;

  mcarb_regbank #(
    .MS_TICK_CYCLES (TICKS)
  ) DUT (
    .clk_sys_in             (clk_sys_in),
    .rst_b_in               (rst_b_in),
    .reg_addr_in            (reg_addr_in),
    .reg_wr_in              (reg_wr_in),
    .reg_rd_in              (reg_rd_in),
    .reg_wdata_in           (reg_wdata_in),
    .reg_rdata_out          (reg_rdata_out),
    .timers_enable_in       (timers_enable_in),
    .dac_test_mode_in       (dac_test_mode_in),
    .gate_auto_in           (gate_auto_in),
    .flag_clear_in          (flag_clear_in),
    .sample_buffer_level_in (sample_buffer_level_in),
    .buffer_full_in         (buffer_full_in),
    .conv_idle_in           (conv_idle_in),
    .conv_track_in          (conv_track_in),
    .conv_settle_in         (conv_settle_in),
    .conversion_done_in     (conversion_done_in),
    .test_dac_out           (test_dac_out),
    .readout_block_size_out (readout_block_size_out),
    .trimmer_control_out    (trimmer_control_out),
    .buffer_clear_out       (buffer_clear_out),
    .soft_reset_out         (soft_reset_out),
    .mem_full_clear_out     (mem_full_clear_out)
  );
  mcarb_host_model host (
    .clk_sys_in    (clk_sys_in),
    .reg_addr_out  (reg_addr_in),
    .reg_wr_out    (reg_wr_in),
    .reg_rd_out    (reg_rd_in),
    .reg_wdata_out (reg_wdata_in),
    .reg_rdata_in  (reg_rdata_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    n_clr += int'(buffer_clear_out === 1'b1);
    n_rst += int'(soft_reset_out === 1'b1);
    n_mfc += int'(mem_full_clear_out === 1'b0 && flag_clear_in === 1'b1);
  end

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // s = {auto, full, idle, track, settle}
  function automatic logic live_ok(input logic [4:0] s);
    return !s[3] && (s[4] ? (s[2] || s[1]) : (s[1] || s[0]));
  endfunction

  task automatic rd32(input logic [7:0] a, output logic [31:0] v);
    logic [15:0] lo, hi;
    host.rd(a, lo);
    host.rd(a + 8'h01, hi);
    v = {hi, lo};
  endtask

  task automatic strobe(input logic [7:0] a, input int exp_rst);
    repeat (3) @(negedge clk_sys_in);
    n_clr = 0;
    n_rst = 0;
    n_mfc = 0;
    host.wr(a, 16'($urandom));
    repeat (3) @(negedge clk_sys_in);
    chk(32'(n_clr), 32'h1);
    chk(32'(n_rst), 32'(exp_rst));
    chk(32'(n_mfc), 32'(exp_rst));
  endtask

  initial begin
    // about twenty times the expected run
    #200000;
    fails++;
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    static logic [7:0]  ra [9] = '{8'h06, 8'h07, 8'h08, 8'h0B, 8'h09, 8'h0A, 8'h13, 8'h14, 8'h15};
    static logic [15:0] rv [9] = '{16'h0000, 16'h0020, 16'h0003, 16'hAAAA, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    static logic [15:0] sh [3] = '{16'h0000, 16'h0020, 16'hAAAA};
    logic [7:0]  trim, a;
    logic [15:0] d, v;
    logic [31:0] sc, rt, lt, rt2;
    logic [4:0]  s;
    int          k, e, c;
    fails = 0;
    n_tests = 0;
    {timers_enable_in, dac_test_mode_in, gate_auto_in, flag_clear_in} = 4'h0;
    {buffer_full_in, conv_idle_in, conv_track_in, conv_settle_in, conversion_done_in} = 5'h00;
    sample_buffer_level_in = 16'h0000;
    void'($urandom(32'h39C8));
    rst_b_in = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    chk(test_dac_out, 32'h0);
    chk(readout_block_size_out, 32'h20);
    chk(trimmer_control_out, 32'h03);
    for (int i = 0; i < 9; i++) begin
      host.rd(ra[i], v);
      chk(v, rv[i]);
    end
    // read-write registers and mirrored outputs
    trim = 8'h03;
    for (int i = 0; i < 16; i++) begin
      host.slow = (i == 0) ? 1'b0 : 1'($urandom);
      dac_test_mode_in = 1'($urandom);
      k = (i == 0) ? 2 : $urandom_range(2, 0);
      a = (k == 0) ? 8'h06 : (k == 1) ? 8'h07 : 8'h0B;
      sh[k] = (i == 0) ? 16'hFFFF : 16'($urandom);
      if (k == 1) host.set_block(sh[k]);
      else host.wr(a, sh[k]);
      host.rd(a, v);
      chk(v, sh[k]);
      chk(test_dac_out, dac_test_mode_in ? sh[0] : 16'h0);
      chk(readout_block_size_out, sh[1]);
      k = $urandom_range(2, 0);
      d = 16'($urandom);
      trim = (k == 0) ? d[7:0] : (k == 1) ? (trim | d[7:0]) : (trim & ~d[7:0]);
      host.wr(8'h08 + 8'(k), d);
      host.rd(8'h08, v);
      chk(v, trim);
      chk(trimmer_control_out, trim);
      sample_buffer_level_in = (i == 1) ? 16'hFFFF : (i == 2) ? 16'h0 : 16'($urandom);
      host.wr(8'h0C, ~sample_buffer_level_in);
      host.rd(8'h0C, v);
      chk(v, sample_buffer_level_in);
    end
    flag_clear_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk(mem_full_clear_out, 32'h1);
    flag_clear_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk(mem_full_clear_out, 32'h0);
    // counters: scaler, real and live time, freeze
    for (int i = 0; i < 10; i++) begin
      strobe(8'h13, 0);
      s = (i == 0) ? 5'h1F : 5'($urandom);
      {gate_auto_in, buffer_full_in, conv_idle_in, conv_track_in, conv_settle_in} = s;
      e = TICKS * $urandom_range(3, 1) + 2;
      c = 0;
      timers_enable_in = 1'b1;
      repeat (e) begin
        conversion_done_in = 1'($urandom);
        c += int'(conversion_done_in);
        @(negedge clk_sys_in);
      end
      timers_enable_in = 1'b0;
      conversion_done_in = 1'b1;
      @(negedge clk_sys_in);
      conversion_done_in = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      host.freeze();
      rd32(8'h0D, sc);
      rd32(8'h0F, rt);
      rd32(8'h11, lt);
      chk(sc, 32'(c));
      chk(rt, 32'(e / TICKS));
      chk(lt, live_ok(s) ? 32'(e / TICKS) : 32'h0);
      timers_enable_in = 1'b1;
      repeat (2 * TICKS) @(negedge clk_sys_in);
      timers_enable_in = 1'b0;
      rd32(8'h0F, rt2);
      chk(rt2, rt);
    end
    flag_clear_in = 1'b1;
    strobe(8'h14, 1);
    flag_clear_in = 1'b0;
    host.freeze();
    rd32(8'h0F, rt);
    chk(rt, 32'h0);
    results();
  end
endmodule

// File: logic/mcarb_cnt_if.sv
// mcarb_cnt_if: enable, clear and value of one 32-bit event counter.
// assumes the counter and its controller share clk_sys_in.
`timescale 1ns/1ps
interface mcarb_cnt_if;
  logic        en;
  logic        clr;
  logic [31:0] value;
  modport ctl (output en, output clr, input value);
  modport cnt (input en, input clr, output value);
endinterface

// File: logic/mcarb_counter.sv
// mcarb_counter: 32-bit event counter, clear wins over count.
// assumes en and clr synchronous to clk_sys_in.
`timescale 1ns/1ps
module mcarb_counter
  import mcarb_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  mcarb_cnt_if.cnt  cnt_if
);

  // ---------------------------------------------------------------
  // count register
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] value_reg;
  logic [CNT_W-1:0] value_next;

  assign value_next   = cnt_if.clr ? '0 : (cnt_if.en ? value_reg + 32'h0000_0001 : value_reg);
  assign cnt_if.value = value_reg;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      value_reg <= '0;
    end else begin
      value_reg <= value_next;
    end
  end

endmodule

// File: logic/mcarb_ms_tick.sv
// mcarb_ms_tick: millisecond prescaler, frozen while disabled.
// assumes CYCLES is at least two.
`timescale 1ns/1ps
module mcarb_ms_tick
  import mcarb_pkg::*;
#(
  parameter int CYCLES = MS_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  input  wire logic enable_in,
  input  wire logic clear_in,
  output logic      tick_out
);

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  logic [31:0] presc_reg;
  logic [31:0] presc_next;
  logic        wrap;

  assign wrap       = (presc_reg == 32'(CYCLES - 1));
  assign tick_out   = enable_in && !clear_in && wrap;
  assign presc_next = clear_in ? 32'h0000_0000 :
                      (!enable_in ? presc_reg : (wrap ? 32'h0000_0000 : presc_reg + 32'h0000_0001));

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      presc_reg <= 32'h0000_0000;
    end else begin
      presc_reg <= presc_next;
    end
  end

endmodule

// File: logic/mcarb_pkg.sv
// mcarb_pkg: register indices, reset values and timing counts of the
// analyzer register bank. assumes one 100 MHz system clock.
package mcarb_pkg;

  // ---------------------------------------------------------------
  // register indices on the register port
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TEST_DAC_VALUE      = 8'h06;
  localparam logic [7:0] ADDR_READOUT_BLOCK_SIZE  = 8'h07;
  localparam logic [7:0] ADDR_TRIMMER_CONTROL     = 8'h08;
  localparam logic [7:0] ADDR_TRIMMER_BIT_SET     = 8'h09;
  localparam logic [7:0] ADDR_TRIMMER_BIT_CLEAR   = 8'h0A;
  localparam logic [7:0] ADDR_TEST_PATTERN        = 8'h0B;
  localparam logic [7:0] ADDR_SAMPLE_BUFFER_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_CONV_COUNT_LOW      = 8'h0D;
  localparam logic [7:0] ADDR_CONV_COUNT_HIGH     = 8'h0E;
  localparam logic [7:0] ADDR_REAL_TIME_LOW       = 8'h0F;
  localparam logic [7:0] ADDR_REAL_TIME_HIGH      = 8'h10;
  localparam logic [7:0] ADDR_LIVE_TIME_LOW       = 8'h11;
  localparam logic [7:0] ADDR_LIVE_TIME_HIGH      = 8'h12;
  localparam logic [7:0] ADDR_SOFT_CLEAR_STROBE   = 8'h13;
  localparam logic [7:0] ADDR_SOFT_RESET_STROBE   = 8'h14;

  // ---------------------------------------------------------------
  // reset values and field widths
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_TEST_DAC_VALUE     = 16'h0000;
  localparam logic [15:0] RST_READOUT_BLOCK_SIZE = 16'h0020;
  localparam logic [7:0]  RST_TRIMMER_CONTROL    = 8'h03;
  localparam logic [15:0] RST_TEST_PATTERN       = 16'hAAAA;
  localparam int          TRIM_W                 = 8;
  localparam int          CNT_W                  = 32;

  // ---------------------------------------------------------------
  // timing: one millisecond tick from the system clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_MS  = 1;
  localparam int MS_CYCLES     = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;

endpackage

// File: logic/mcarb_regbank.sv
// mcarb_regbank: register bank of the analyzer: test dac, block size,
// trimmer, scratch, occupancy, scaler, real and live timers, strobes.
// assumes a synchronous register port and control bits from the
// control register arriving as plain inputs.
`timescale 1ns/1ps
module mcarb_regbank
  import mcarb_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  wire logic        timers_enable_in,
  input  wire logic        dac_test_mode_in,
  input  wire logic        gate_auto_in,
  input  wire logic        flag_clear_in,
  input  wire logic [15:0] sample_buffer_level_in,
  input  wire logic        buffer_full_in,
  input  wire logic        conv_idle_in,
  input  wire logic        conv_track_in,
  input  wire logic        conv_settle_in,
  input  wire logic        conversion_done_in,
  output logic      [15:0] test_dac_out,
  output logic      [15:0] readout_block_size_out,
  output logic      [7:0]  trimmer_control_out,
  output logic             buffer_clear_out,
  output logic             soft_reset_out,
  output logic             mem_full_clear_out
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire wr_dac     = reg_wr_in && (reg_addr_in == ADDR_TEST_DAC_VALUE);
  wire wr_block   = reg_wr_in && (reg_addr_in == ADDR_READOUT_BLOCK_SIZE);
  wire wr_trim    = reg_wr_in && (reg_addr_in == ADDR_TRIMMER_CONTROL);
  wire wr_tset    = reg_wr_in && (reg_addr_in == ADDR_TRIMMER_BIT_SET);
  wire wr_tclr    = reg_wr_in && (reg_addr_in == ADDR_TRIMMER_BIT_CLEAR);
  wire wr_pattern = reg_wr_in && (reg_addr_in == ADDR_TEST_PATTERN);
  wire wr_freeze  = reg_wr_in && (reg_addr_in == ADDR_REAL_TIME_LOW);
  wire wr_sclear  = reg_wr_in && (reg_addr_in == ADDR_SOFT_CLEAR_STROBE);
  wire wr_sreset  = reg_wr_in && (reg_addr_in == ADDR_SOFT_RESET_STROBE);
  wire clear_all  = wr_sclear || wr_sreset;

  // ---------------------------------------------------------------
  // host registers
  // ---------------------------------------------------------------
  logic [15:0]       test_dac_value_reg;
  logic [15:0]       block_size_reg;
  logic [TRIM_W-1:0] trimmer_reg;
  logic [TRIM_W-1:0] trimmer_next;
  logic [15:0]       test_pattern_reg;

  always_comb begin
    trimmer_next = trimmer_reg;
    if (wr_trim) begin
      trimmer_next = reg_wdata_in[TRIM_W-1:0];
    end else if (wr_tset) begin
      trimmer_next = trimmer_reg | reg_wdata_in[TRIM_W-1:0];
    end else if (wr_tclr) begin
      trimmer_next = trimmer_reg & ~reg_wdata_in[TRIM_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      test_dac_value_reg <= RST_TEST_DAC_VALUE;
      block_size_reg     <= RST_READOUT_BLOCK_SIZE;
      trimmer_reg        <= RST_TRIMMER_CONTROL;
      test_pattern_reg   <= RST_TEST_PATTERN;
    end else begin
      if (wr_dac) begin
        test_dac_value_reg <= reg_wdata_in;
      end
      if (wr_block) begin
        block_size_reg <= reg_wdata_in;
      end
      trimmer_reg <= trimmer_next;
      if (wr_pattern) begin
        test_pattern_reg <= reg_wdata_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs toward the analog side and acquisition logic
  // ---------------------------------------------------------------
  wire [15:0] test_dac_next = dac_test_mode_in ? test_dac_value_reg : 16'h0000;
  wire        flag_clr_next = flag_clear_in && !wr_sreset;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      test_dac_out           <= 16'h0000;
      readout_block_size_out <= RST_READOUT_BLOCK_SIZE;
      trimmer_control_out    <= RST_TRIMMER_CONTROL;
      buffer_clear_out       <= 1'b0;
      soft_reset_out         <= 1'b0;
      mem_full_clear_out     <= 1'b0;
    end else begin
      test_dac_out           <= test_dac_next;
      readout_block_size_out <= block_size_reg;
      trimmer_control_out    <= trimmer_reg;
      buffer_clear_out       <= clear_all;
      soft_reset_out         <= wr_sreset;
      mem_full_clear_out     <= flag_clr_next;
    end
  end

  // ---------------------------------------------------------------
  // millisecond tick and counters
  // ---------------------------------------------------------------
  logic ms_tick;
  logic live_ok;

  mcarb_cnt_if scaler_if ();
  mcarb_cnt_if real_if ();
  mcarb_cnt_if live_if ();

  mcarb_ms_tick #(
    .CYCLES (MS_TICK_CYCLES)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .enable_in  (timers_enable_in),
    .clear_in   (clear_all),
    .tick_out   (ms_tick)
  );

  assign live_ok = !buffer_full_in &&
                   (gate_auto_in ? (conv_idle_in || conv_track_in)
                                 : (conv_track_in || conv_settle_in));

  assign scaler_if.en  = timers_enable_in && conversion_done_in;
  assign scaler_if.clr = clear_all;
  assign real_if.en    = ms_tick;
  assign real_if.clr   = clear_all;
  assign live_if.en    = ms_tick && live_ok;
  assign live_if.clr   = clear_all;

  mcarb_counter u_scaler (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .cnt_if     (scaler_if)
  );

  mcarb_counter u_real (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .cnt_if     (real_if)
  );

  mcarb_counter u_live (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .cnt_if     (live_if)
  );

  // ---------------------------------------------------------------
  // frozen copies read by the host
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] snap_scaler_reg;
  logic [CNT_W-1:0] snap_real_reg;
  logic [CNT_W-1:0] snap_live_reg;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      snap_scaler_reg <= '0;
      snap_real_reg   <= '0;
      snap_live_reg   <= '0;
    end else if (clear_all) begin
      snap_scaler_reg <= '0;
      snap_real_reg   <= '0;
      snap_live_reg   <= '0;
    end else if (wr_freeze) begin
      snap_scaler_reg <= scaler_if.value;
      snap_real_reg   <= real_if.value;
      snap_live_reg   <= live_if.value;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [15:0] rd_mux;

  always_comb begin
    case (reg_addr_in)
      ADDR_TEST_DAC_VALUE:      rd_mux = test_dac_value_reg;
      ADDR_READOUT_BLOCK_SIZE:  rd_mux = block_size_reg;
      ADDR_TRIMMER_CONTROL:     rd_mux = {8'h00, trimmer_reg};
      ADDR_TEST_PATTERN:        rd_mux = test_pattern_reg;
      ADDR_SAMPLE_BUFFER_LEVEL: rd_mux = sample_buffer_level_in;
      ADDR_CONV_COUNT_LOW:      rd_mux = snap_scaler_reg[15:0];
      ADDR_CONV_COUNT_HIGH:     rd_mux = snap_scaler_reg[31:16];
      ADDR_REAL_TIME_LOW:       rd_mux = snap_real_reg[15:0];
      ADDR_REAL_TIME_HIGH:      rd_mux = snap_real_reg[31:16];
      ADDR_LIVE_TIME_LOW:       rd_mux = snap_live_reg[15:0];
      ADDR_LIVE_TIME_HIGH:      rd_mux = snap_live_reg[31:16];
      default:                  rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  chk_dac_test_drive: assert property (
    dac_test_mode_in |=> test_dac_out == $past(test_dac_value_reg))
    else $error("test dac does not follow dac value");

  chk_dac_test_off: assert property (
    !dac_test_mode_in |=> test_dac_out == 16'h0000)
    else $error("test dac driven outside test mode");

  chk_block_size_use: assert property (
    wr_block |=> ##1 readout_block_size_out == $past(reg_wdata_in, 2))
    else $error("block size not applied");

  chk_trim_bit_set: assert property (
    wr_tset |=> ##1 trimmer_control_out == ($past(trimmer_reg, 2) | $past(reg_wdata_in[7:0], 2)))
    else $error("trimmer bit set wrong");

  chk_trim_bit_clear: assert property (
    wr_tclr |=> ##1 trimmer_control_out == ($past(trimmer_reg, 2) & ~$past(reg_wdata_in[7:0], 2)))
    else $error("trimmer bit clear wrong");

  chk_scratch_readback: assert property (
    wr_pattern ##1 !wr_pattern ##1 (reg_rd_in && reg_addr_in == ADDR_TEST_PATTERN && !reg_wr_in)
      |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("scratch readback mismatch");

  chk_level_read: assert property (
    reg_rd_in && reg_addr_in == ADDR_SAMPLE_BUFFER_LEVEL |=> reg_rdata_out == $past(sample_buffer_level_in))
    else $error("buffer level read wrong");

  chk_scaler_count: assert property (
    timers_enable_in && conversion_done_in && !clear_all |=> scaler_if.value == $past(scaler_if.value) + 32'h1)
    else $error("scaler missed a conversion");

  chk_timers_hold: assert property (
    !timers_enable_in && !clear_all |=> $stable(real_if.value) && $stable(live_if.value) && $stable(scaler_if.value))
    else $error("timers moved while disabled");

  chk_freeze_capture: assert property (
    wr_freeze && !clear_all |=> snap_real_reg == $past(real_if.value) && snap_live_reg == $past(live_if.value)
      && snap_scaler_reg == $past(scaler_if.value))
    else $error("freeze did not capture counters");

  chk_live_auto_gate: assert property (
    gate_auto_in && !(conv_idle_in || conv_track_in) && !clear_all |=> $stable(live_if.value))
    else $error("live time counted outside idle or track");

  chk_live_ext_gate: assert property (
    !gate_auto_in && (buffer_full_in || !(conv_track_in || conv_settle_in)) && !clear_all
      |=> $stable(live_if.value))
    else $error("live time counted outside track or settle");

  chk_clear_zeroes: assert property (
    wr_sclear |=> buffer_clear_out && scaler_if.value == 32'h0 && real_if.value == 32'h0 && live_if.value == 32'h0)
    else $error("soft clear left counters");

  chk_reset_strobe: assert property (
    wr_sreset |=> soft_reset_out && buffer_clear_out && !mem_full_clear_out)
    else $error("soft reset strobe missing");

  chk_flag_clear_follow: assert property (
    flag_clear_in && !wr_sreset |=> mem_full_clear_out)
    else $error("memory full clear not forced");

  chk_real_tick: assert property (
    ms_tick && !clear_all |=> real_if.value == $past(real_if.value) + 32'h1)
    else $error("real time missed a tick");

  chk_dac_value_write: assert property (
    wr_dac |=> test_dac_value_reg == $past(reg_wdata_in))
    else $error("dac value write lost");

  chk_trim_direct_write: assert property (
    wr_trim |=> ##1 trimmer_control_out == $past(reg_wdata_in[7:0], 2))
    else $error("trimmer word write lost");

  chk_flag_clear_rearm: assert property (
    !flag_clear_in |=> !mem_full_clear_out)
    else $error("memory full clear stuck");

  chk_snap_cleared: assert property (
    clear_all |=> snap_scaler_reg == 32'h0 && snap_real_reg == 32'h0 && snap_live_reg == 32'h0)
    else $error("frozen copies survived a clear");

  chk_freeze_hold: assert property (
    !wr_freeze && !clear_all |=> $stable(snap_scaler_reg) && $stable(snap_real_reg) && $stable(snap_live_reg))
    else $error("frozen copies moved without a freeze");

  chk_live_auto_count: assert property (
    ms_tick && gate_auto_in && !buffer_full_in && (conv_idle_in || conv_track_in) && !clear_all
      |=> live_if.value == $past(live_if.value) + 32'h1)
    else $error("auto gate live time missed a tick");

  chk_live_ext_count: assert property (
    ms_tick && !gate_auto_in && !buffer_full_in && (conv_track_in || conv_settle_in) && !clear_all
      |=> live_if.value == $past(live_if.value) + 32'h1)
    else $error("external gate live time missed a tick");

  chk_live_full_hold: assert property (
    buffer_full_in && !clear_all |=> $stable(live_if.value))
    else $error("live time counted while buffer full");

  logic [31:0] tick_gap_reg;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_gap_reg <= 32'h0000_0000;
    end else if (clear_all || ms_tick) begin
      tick_gap_reg <= 32'h0000_0000;
    end else if (timers_enable_in) begin
      tick_gap_reg <= tick_gap_reg + 32'h0000_0001;
    end
  end

  chk_tick_period: assert property (
    timers_enable_in && !clear_all |-> ms_tick == (tick_gap_reg == 32'(MS_TICK_CYCLES - 1)))
    else $error("millisecond tick off period");

endmodule
